// File: iopim_pkg.sv
package iopim_pkg;
  // ---------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CFG       = 8'h04;
  localparam logic [7:0] ADDR_OUT_IMG   = 8'h08;
  localparam logic [7:0] ADDR_IN_WORD   = 8'h0C;
  localparam logic [7:0] ADDR_IN_BYTE4  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1C;
  localparam logic [7:0] ADDR_CONN_STAT = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_OPEN_BIT   = 0;  // Request to open connection
  localparam int CTRL_CLOSE_BIT  = 1;  // Close connection
  localparam int CTRL_TYPE_LSB   = 2;  // Connection type, two bits
  localparam int CTRL_MCAST_BIT  = 4;  // Device-to-scanner multicast
  localparam int CTRL_CFGV_BIT   = 5;  // Configuration image present
  localparam int CTRL_OUTLEN_LSB = 8;  // Output image length, 2 bits
  localparam int CFG_POLICY_LSB  = 0;
  localparam int CFG_PATTERN_LSB = 8;
  localparam int NUM_DIAG        = 6;
  localparam int NUM_DO          = 4;
  localparam int NUM_DI          = 8;

  // ---------------------------------------------------------------
  // Image sizes and instances
  // ---------------------------------------------------------------
  localparam logic [7:0] IN_IMG_LEN      = 8'h05;
  localparam logic [7:0] OUT_LEN_OWNER   = 8'h01;
  localparam logic [7:0] CFG_IMG_LEN     = 8'h02;
  localparam logic [7:0] INST_OUT        = 8'h64;  // 100
  localparam logic [7:0] INST_IN         = 8'h65;  // 101
  localparam logic [7:0] INST_CFG        = 8'h66;  // 102

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_POLICY_RST  = 8'h00;
  localparam logic [7:0] CFG_PATTERN_RST = 8'h00;
  localparam logic [1:0] POL_LOW         = 2'h0;
  localparam logic [1:0] POL_HIGH        = 2'h1;
  localparam logic [1:0] POL_HOLD        = 2'h2;
  localparam logic [1:0] POL_PATTERN     = 2'h3;
  localparam logic [1:0] CT_OWNER        = 2'h0;
  localparam logic [1:0] CT_INPUT_ONLY   = 2'h1;
  localparam logic [1:0] CT_LISTEN_ONLY  = 2'h2;
  localparam logic [1:0] CT_NONE         = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int READY_MS      = 350;
  localparam int ESTABLISH_MS  = 500;
  localparam int RING_MS       = 3;
  localparam int READY_CYC     = READY_MS * (CLK_HZ / 1000) - 1;
  localparam int ESTABLISH_CYC = ESTABLISH_MS * (CLK_HZ / 1000) - 1;
  localparam int RING_CYC      = RING_MS * (CLK_HZ / 1000) - 1;
  localparam int WDOG_CYC      = 20_000;
  localparam logic [3:0] SEL_FACTORY = 4'hF;

  typedef enum logic [1:0] {IOPIM_BOOT, IOPIM_IDLE, IOPIM_OPENING, IOPIM_RUN} iopim_state_t;
endpackage

// File: iopim_subst.sv
`timescale 1ns/1ps
module iopim_subst (
  input  wire logic       clk_i,        // Clock
  input  wire logic       rst_n_i,      // Sync reset, active low
  input  wire logic       ce_i,         // Clock enable
  input  wire logic       live_i,       // Valid owner image present
  input  wire logic [7:0] out_byte_i,   // Received output byte
  input  wire logic [1:0] policy_i,     // Substitute policy
  input  wire logic [7:0] pattern_i,    // Substitute pattern
  output logic      [3:0] do_o          // Digital outputs
);
  logic [3:0] do_r;
  logic [3:0] do_nxt;

  // Live data or substitute value
  always_comb begin
    do_nxt = do_r;
    if (live_i) begin
      do_nxt = out_byte_i[3:0];
    end else begin
      case (policy_i)
        iopim_pkg::POL_LOW:     do_nxt = 4'h0;
        iopim_pkg::POL_HIGH:    do_nxt = 4'hF;
        iopim_pkg::POL_HOLD:    do_nxt = do_r;
        iopim_pkg::POL_PATTERN: do_nxt = pattern_i[3:0];
        default:                do_nxt = 4'h0;
      endcase
    end
  end

  // Output register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      do_r <= 4'h0;
    end else if (ce_i) begin
      do_r <= do_nxt;
    end
  end

  assign do_o = do_r;
endmodule // iopim_subst

// File: iopim_ring.sv
`timescale 1ns/1ps
module iopim_ring (
  input  wire logic clk_i,         // Clock
  input  wire logic rst_n_i,       // Sync reset, active low
  input  wire logic ce_i,          // Clock enable
  input  wire logic beacon_i,      // Ring beacon seen, pulse
  output logic      fault_o,       // Ring fault, level
  output logic      fault_evt_o    // Fault detected, pulse
);
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic        flt_r;
  logic        flt_nxt;
  logic        evt_r;
  logic        evt_nxt;

  // Beacon timeout; single ring only
  always_comb begin
    cnt_nxt = cnt_r;
    flt_nxt = flt_r;
    evt_nxt = 1'b0;
    if (beacon_i) begin
      cnt_nxt = 17'h0_0000;
      flt_nxt = 1'b0;
    end else if (cnt_r == 17'(iopim_pkg::RING_CYC)) begin
      flt_nxt = 1'b1;
      evt_nxt = !flt_r;
    end else begin
      cnt_nxt = cnt_r + 17'h0_0001;
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 17'h0_0000;
      flt_r <= 1'b0;
      evt_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      flt_r <= flt_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign fault_o     = flt_r;
  assign fault_evt_o = evt_r;
endmodule // iopim_ring

// File: iopim_top.sv
// Behaviour
// - Every connection type gets a five byte input image.
// - Output image is one byte for owner, zero for input-only and listen-only.
// - Owner and input-only carry a two byte configuration image, listen-only none.
// - Bits 0..3 of output byte 0 (instance 100) drive outputs 1..4, bits 4..7 ignored.
// - Input image (instance 101) has status in bytes 0..3 and inputs in byte 4.
// - Status bits 0..5 report the six diagnostics, bits 6..31 reserved zero.
// - Bits 0..7 of input byte 4 reflect digital inputs 1..8.
// - Config byte 0 selects low, high, hold or pattern, default low.
// - Config byte 1 is the pattern, default zero, used only under policy 3.
// - After power up a connection request is accepted within 350 ms.
// - A cyclic connection is established within 500 ms.
// - Owner and input-only accept multicast or point-to-point delivery.
// - A ring fault is detected and reported within 3 ms, single ring only.
// - Selector position 0F restores factory defaults.
`timescale 1ns/1ps
module iopim_top (
  input  wire logic        clk_i,         // Clock, 20 MHz
  input  wire logic        rst_n_i,       // Sync reset, active low
  input  wire logic        ce_i,          // Clock enable
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic [7:0]  digital_input_i, // Digital inputs 1..8
  input  wire logic [5:0]  diag_i,        // Diagnostic flags
  input  wire logic [3:0]  selector_i,    // Rotary selector
  input  wire logic        ring_beacon_i, // Ring beacon pulse
  output logic      [3:0]  do_o,          // Digital outputs 1..4
  output logic             ring_fault_o,  // Ring fault level
  output logic             conn_up_o,     // Connection running
  output logic             irq_o          // Interrupt level
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  iopim_pkg::iopim_state_t st_r, st_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [7:0]  policy_r, policy_nxt;
  logic [7:0]  pattern_r, pattern_nxt;
  logic [7:0]  out_img_r, out_img_nxt;
  logic [1:0]  ctype_r, ctype_nxt;
  logic        mcast_r, mcast_nxt;
  logic        refused_r, refused_nxt;
  logic [14:0] wdog_r, wdog_nxt;
  logic        live_r, live_nxt;
  logic [7:0]  di_r;
  logic [5:0]  diag_r;
  logic [3:0]  irq_st_r, irq_st_nxt;
  logic [3:0]  irq_mk_r, irq_mk_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r;
  logic        conn_r;
  logic        ring_flt;
  logic        ring_evt;
  logic        wr_en;
  logic        rd_en;
  logic [3:0]  evt;

  // Register access strobes, one cycle per APB access
  assign wr_en = psel && penable && pwrite && !pready_r;
  assign rd_en = psel && penable && !pwrite && !pready_r;

  // Legal connection check
  function automatic logic conn_ok(input logic [1:0] ct, input logic mc, input logic cfgv,
                                   input logic [1:0] olen);
    logic ok;
    ok = 1'b0;
    case (ct)
      iopim_pkg::CT_OWNER:       ok = cfgv && (olen == 2'(iopim_pkg::OUT_LEN_OWNER));
      iopim_pkg::CT_INPUT_ONLY:  ok = cfgv && (olen == 2'h0);
      iopim_pkg::CT_LISTEN_ONLY: ok = mc && !cfgv && (olen == 2'h0);
      default:                   ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // Connection sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    tmr_nxt     = tmr_r;
    ctype_nxt   = ctype_r;
    mcast_nxt   = mcast_r;
    refused_nxt = refused_r;
    case (st_r)
      iopim_pkg::IOPIM_BOOT: begin
        if (tmr_r == 24'(iopim_pkg::READY_CYC)) begin
          st_nxt  = iopim_pkg::IOPIM_IDLE;
          tmr_nxt = 24'h00_0000;
        end else begin
          tmr_nxt = tmr_r + 24'h00_0001;
        end
        // Open request before ready is refused, not queued
        if (wr_en && paddr == iopim_pkg::ADDR_CTRL && pwdata[iopim_pkg::CTRL_OPEN_BIT]) begin
          refused_nxt = 1'b1;
        end
      end
      iopim_pkg::IOPIM_IDLE: begin
        if (wr_en && paddr == iopim_pkg::ADDR_CTRL && pwdata[iopim_pkg::CTRL_OPEN_BIT]) begin
          if (conn_ok(pwdata[iopim_pkg::CTRL_TYPE_LSB +: 2], pwdata[iopim_pkg::CTRL_MCAST_BIT],
                      pwdata[iopim_pkg::CTRL_CFGV_BIT], pwdata[iopim_pkg::CTRL_OUTLEN_LSB +: 2])) begin
            st_nxt      = iopim_pkg::IOPIM_OPENING;
            ctype_nxt   = pwdata[iopim_pkg::CTRL_TYPE_LSB +: 2];
            mcast_nxt   = pwdata[iopim_pkg::CTRL_MCAST_BIT];
            refused_nxt = 1'b0;
            tmr_nxt     = 24'h00_0000;
          end else begin
            refused_nxt = 1'b1;
          end
        end
      end
      iopim_pkg::IOPIM_OPENING: begin
        if (tmr_r == 24'h00_0007 || tmr_r == 24'(iopim_pkg::ESTABLISH_CYC)) begin
          st_nxt = iopim_pkg::IOPIM_RUN;
        end else begin
          tmr_nxt = tmr_r + 24'h00_0001;
        end
      end
      default: begin
        if (wr_en && paddr == iopim_pkg::ADDR_CTRL && pwdata[iopim_pkg::CTRL_CLOSE_BIT]) begin
          st_nxt    = iopim_pkg::IOPIM_IDLE;
          ctype_nxt = iopim_pkg::CT_NONE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r      <= iopim_pkg::IOPIM_BOOT;
      tmr_r     <= 24'h00_0000;
      ctype_r   <= iopim_pkg::CT_NONE;
      mcast_r   <= 1'b0;
      refused_r <= 1'b0;
    end else if (ce_i) begin
      st_r      <= st_nxt;
      tmr_r     <= tmr_nxt;
      ctype_r   <= ctype_nxt;
      mcast_r   <= mcast_nxt;
      refused_r <= refused_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Configuration and output image
  // ---------------------------------------------------------------
  always_comb begin
    policy_nxt  = policy_r;
    pattern_nxt = pattern_r;
    out_img_nxt = out_img_r;
    wdog_nxt    = wdog_r;
    live_nxt    = 1'b0;
    if (selector_i == iopim_pkg::SEL_FACTORY) begin
      policy_nxt  = iopim_pkg::CFG_POLICY_RST;
      pattern_nxt = iopim_pkg::CFG_PATTERN_RST;
    end else if (wr_en && paddr == iopim_pkg::ADDR_CFG && ctype_r != iopim_pkg::CT_LISTEN_ONLY) begin
      if (pwdata[iopim_pkg::CFG_POLICY_LSB +: 8] <= 8'h03) begin
        policy_nxt = pwdata[iopim_pkg::CFG_POLICY_LSB +: 8];
      end
      pattern_nxt = pwdata[iopim_pkg::CFG_PATTERN_LSB +: 8];
    end
    if (wr_en && paddr == iopim_pkg::ADDR_OUT_IMG && ctype_r == iopim_pkg::CT_OWNER) begin
      out_img_nxt = pwdata[7:0];
      wdog_nxt    = 15'h0000;
    end else if (wdog_r != 15'(iopim_pkg::WDOG_CYC)) begin
      wdog_nxt = wdog_r + 15'h0001;
    end
    live_nxt = (st_r == iopim_pkg::IOPIM_RUN) && (ctype_r == iopim_pkg::CT_OWNER)
               && (wdog_nxt != 15'(iopim_pkg::WDOG_CYC));
  end

  // Configuration registers, inputs sampled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      policy_r  <= iopim_pkg::CFG_POLICY_RST;
      pattern_r <= iopim_pkg::CFG_PATTERN_RST;
      out_img_r <= 8'h00;
      wdog_r    <= 15'(iopim_pkg::WDOG_CYC);
      live_r    <= 1'b0;
      di_r      <= 8'h00;
      diag_r    <= 6'h00;
    end else if (ce_i) begin
      policy_r  <= policy_nxt;
      pattern_r <= pattern_nxt;
      out_img_r <= out_img_nxt;
      wdog_r    <= wdog_nxt;
      live_r    <= live_nxt;
      di_r      <= digital_input_i;
      diag_r    <= diag_i;
    end
  end

  // ---------------------------------------------------------------
  // APB slave and interrupts
  // ---------------------------------------------------------------
  assign evt = {refused_nxt && !refused_r, ring_evt, |(diag_i & ~diag_r),
                (st_nxt == iopim_pkg::IOPIM_RUN) && (st_r != iopim_pkg::IOPIM_RUN)};

  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    irq_mk_nxt  = irq_mk_r;
    irq_st_nxt  = irq_st_r;
    if (rd_en && paddr == iopim_pkg::ADDR_IRQ_STAT) begin
      irq_st_nxt = 4'h0;
    end
    irq_st_nxt = irq_st_nxt | evt;  // Set wins over read clear
    if (wr_en && paddr == iopim_pkg::ADDR_IRQ_MASK) begin
      irq_mk_nxt = pwdata[3:0];
    end
    if (rd_en) begin
      if (paddr == iopim_pkg::ADDR_CTRL) begin
        prdata_nxt = {26'h000_0000, mcast_r, 1'b0, ctype_r, 2'h0};
      end else if (paddr == iopim_pkg::ADDR_CFG) begin
        prdata_nxt = {16'h0000, pattern_r, policy_r};
      end else if (paddr == iopim_pkg::ADDR_OUT_IMG) begin
        prdata_nxt = {24'h00_0000, out_img_r};
      end else if (paddr == iopim_pkg::ADDR_IN_WORD) begin
        prdata_nxt = {26'h000_0000, diag_r};
      end else if (paddr == iopim_pkg::ADDR_IN_BYTE4) begin
        prdata_nxt = {24'h00_0000, di_r};
      end else if (paddr == iopim_pkg::ADDR_STATUS) begin
        prdata_nxt = {16'h0000, iopim_pkg::IN_IMG_LEN,
                      (ctype_r == iopim_pkg::CT_LISTEN_ONLY) ? 4'h0 : iopim_pkg::CFG_IMG_LEN[3:0],
                      (ctype_r == iopim_pkg::CT_OWNER) ? iopim_pkg::OUT_LEN_OWNER[3:0] : 4'h0};
      end else if (paddr == iopim_pkg::ADDR_IRQ_STAT) begin
        prdata_nxt = {28'h000_0000, irq_st_r};
      end else if (paddr == iopim_pkg::ADDR_IRQ_MASK) begin
        prdata_nxt = {28'h000_0000, irq_mk_r};
      end else if (paddr == iopim_pkg::ADDR_CONN_STAT) begin
        prdata_nxt = {27'h000_0000, ring_flt, refused_r, live_r, 2'(st_r)};
      end else begin
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b1;
      end
    end else if (wr_en && paddr != iopim_pkg::ADDR_CTRL && paddr != iopim_pkg::ADDR_CFG
                 && paddr != iopim_pkg::ADDR_OUT_IMG && paddr != iopim_pkg::ADDR_IRQ_MASK) begin
      pslverr_nxt = 1'b1;
    end
  end

  // Bus and interrupt registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_st_r  <= 4'h0;
      irq_mk_r  <= 4'h0;
      irq_r     <= 1'b0;
      conn_r    <= 1'b0;
    end else if (ce_i) begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_st_r  <= irq_st_nxt;
      irq_mk_r  <= irq_mk_nxt;
      irq_r     <= |(irq_st_nxt & irq_mk_nxt);
      conn_r    <= st_nxt == iopim_pkg::IOPIM_RUN;
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  iopim_subst u_subst (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .live_i     (live_r),
    .out_byte_i (out_img_r),
    .policy_i   (policy_r[1:0]),
    .pattern_i  (pattern_r),
    .do_o       (do_o)
  );

  iopim_ring u_ring (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .beacon_i    (ring_beacon_i),
    .fault_o     (ring_flt),
    .fault_evt_o (ring_evt)
  );

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign irq_o        = irq_r;
  assign conn_up_o    = conn_r;
  assign ring_fault_o = ring_flt;
endmodule // iopim_top

// File: iopim_chk.sv
`timescale 1ns/1ps
module iopim_chk (
  input wire logic        clk_i,           // Clock
  input wire logic        rst_n_i,         // Reset, low
  input wire logic        psel,            // APB select
  input wire logic        penable,         // APB enable
  input wire logic        pwrite,          // APB direction
  input wire logic [7:0]  paddr,           // APB address
  input wire logic [31:0] prdata,          // APB read data
  input wire logic        pready,          // APB ready
  input wire logic        pslverr,         // APB error
  input wire logic [7:0]  digital_input_i, // Inputs 1..8
  input wire logic [3:0]  selector_i,      // Rotary selector
  input wire logic        ring_beacon_i,   // Ring beacon
  input wire logic [3:0]  do_o,            // Outputs 1..4
  input wire logic        ring_fault_o,    // Ring fault
  input wire logic        conn_up_o        // Connection running
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  localparam int RING_LIM = 60000;
  logic [16:0] quiet_r;
  logic [16:0] quiet_nxt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Cycles since the last ring beacon, saturating
  always_comb begin
    quiet_nxt = quiet_r;
    if (ring_beacon_i) begin
      quiet_nxt = 17'h0_0000;
    end else if (quiet_r != 17'h1_ffff) begin
      quiet_nxt = quiet_r + 17'h0_0001;
    end
  end

  // Counter register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      quiet_r <= 17'h0_0000;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end

  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && pready && paddr == a;
  endsequence

  property p_ready; s_access |-> ##[0:2] pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err;
    psel && penable && pready && paddr > iopim_pkg::ADDR_CONN_STAT
      |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  property p_len; s_rd(iopim_pkg::ADDR_STATUS) |-> prdata[15:8] == 8'h05; endproperty
  property p_word; s_rd(iopim_pkg::ADDR_IN_WORD) |-> prdata[31:6] == '0; endproperty
  property p_di;
    s_rd(iopim_pkg::ADDR_IN_BYTE4) ##0 digital_input_i == $past(digital_input_i, 3)
      |-> prdata == {24'h00_0000, digital_input_i};
  endproperty
  property p_fact; (selector_i == 4'hf && !conn_up_o) [*6] |-> do_o == 4'h0; endproperty
  property p_fcfg;
    s_rd(iopim_pkg::ADDR_CFG) ##0 selector_i == 4'hf && $past(selector_i, 2) == 4'hf
      |-> prdata[15:0] == 16'h0000;
  endproperty
  property p_flt; quiet_r > RING_LIM + 3 |-> ring_fault_o; endproperty
  property p_clr; ring_beacon_i |-> ##[1:3] !ring_fault_o; endproperty

  a_ready: assert property (p_ready) else $error("ready late");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_len: assert property (p_len) else $error("input length wrong");
  a_word: assert property (p_word) else $error("reserved status bits set");
  a_di: assert property (p_di) else $error("input byte wrong");
  a_fact: assert property (p_fact) else $error("factory outputs wrong");
  a_fcfg: assert property (p_fcfg) else $error("factory config wrong");
  a_flt: assert property (p_flt) else $error("ring fault missed");
  a_clr: assert property (p_clr) else $error("ring fault kept");
endmodule // iopim_chk

bind iopim_top iopim_chk u_chk (.*);

// File: iopim_scanner.sv
`timescale 1ns/1ps
module iopim_scanner (
  input  wire logic        clk_i,         // Clock
  input  wire logic [31:0] prdata,        // APB read data
  input  wire logic        pready,        // APB ready
  input  wire logic        pslverr,       // APB error
  input  wire logic        beacon_en_i,   // Ring intact
  output logic             psel,          // APB select
  output logic             penable,       // APB enable
  output logic             pwrite,        // APB direction
  output logic      [7:0]  paddr,         // APB address
  output logic      [31:0] pwdata,        // APB write data
  output logic             ring_beacon_o  // Ring beacon
);
  // ----------------------------------------
  // Scanner side
  // ----------------------------------------
  int cnt = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ring_beacon_o = 1'b0;
  end

  // Beacon every 1000 cycles while the ring is whole
  always @(posedge clk_i) begin
    cnt <= (cnt == 999) ? 0 : cnt + 1;
    ring_beacon_o <= beacon_en_i && cnt == 999;
  end

  // One APB transfer, bounded wait on ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic tmo);
    q = 32'h0000_0000;
    err = 1'b0;
    tmo = 1'b1;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    for (int n = 0; n < 50 && tmo; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) begin
        tmo = 1'b0;
        q = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;    // Released lines show no stale value
    pwdata <= ~d;
  endtask

  // Connection request word for each connection type
  function automatic logic [31:0] ctrl_word(input logic [1:0] ct, input logic mc);
    logic [31:0] w;
    w = {22'h0, 2'b00, 2'b00, 1'b0, mc, ct, 2'b01};
    if (ct == iopim_pkg::CT_LISTEN_ONLY) begin
      w[4] = 1'b1;
    end else begin
      w[5] = 1'b1;
      w[9:8] = (ct == iopim_pkg::CT_OWNER) ? 2'b01 : 2'b00;
    end
    return w;
  endfunction
endmodule // iopim_scanner

// File: testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ring_beacon, ring_fault_o, conn_up_o, irq_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [7:0] digital_input_i = 8'h00;
  logic [5:0] diag_i = 6'h00;
  logic [3:0] selector_i = 4'h0;
  logic [3:0] do_o, m_do;
  logic [7:0] m_pat;
  logic e, beacon_en = 1'b1;
  int n_errors, tests_run, m_pol;

  // Clock
  always #25 clk_i = ~clk_i;

  iopim_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_input_i(digital_input_i), .diag_i(diag_i),
    .selector_i(selector_i), .ring_beacon_i(ring_beacon), .do_o(do_o),
    .ring_fault_o(ring_fault_o), .conn_up_o(conn_up_o), .irq_o(irq_o));
  iopim_scanner u_scan (.clk_i(clk_i), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .beacon_en_i(beacon_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .ring_beacon_o(ring_beacon));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected outputs when no owner image is live
  function automatic logic [3:0] subst(input int pol, input logic [7:0] pat, input logic [3:0] l);
    case (pol)
      0: return 4'h0;
      1: return 4'hf;
      2: return l;
      default: return pat[3:0];
    endcase
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic tmo;
    u_scan.xfer(wr, a, d, q, e, tmo);
    if (tmo) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      stop_test();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Main sequence
  initial begin
    n_errors = 0;
    tests_run = 0;
    seed = 32'h09b9_56b8;
    m_do = 4'h0;
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(1);
    acc(1'b0, iopim_pkg::ADDR_CFG, 32'h0); `CHK(q[15:0], 16'h0000)
    acc(1'b0, iopim_pkg::ADDR_STATUS, 32'h0); `CHK(q[15:8], 8'h05)
    `CHK(do_o, 4'h0)
    acc(1'b0, 8'h24, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      digital_input_i <= seed[7:0];
      diag_i <= seed[13:8];
      cyc(4);
      acc(1'b0, iopim_pkg::ADDR_IN_BYTE4, 32'h0); `CHK(q, {24'h0, seed[7:0]})
      acc(1'b0, iopim_pkg::ADDR_IN_WORD, 32'h0); `CHK(q, {26'h0, seed[13:8]})
    end
    $display("test inputs done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      m_pol = 3 - i;
      m_pat = seed[23:16];
      acc(1'b1, iopim_pkg::ADDR_CFG, {16'h0, m_pat, 8'(m_pol)});
      m_do = subst(m_pol, m_pat, m_do);
      cyc(3);
      `CHK(do_o, m_do)
      acc(1'b0, iopim_pkg::ADDR_CFG, 32'h0); `CHK(q[15:0], {m_pat, 8'(m_pol)})
      acc(1'b1, iopim_pkg::ADDR_OUT_IMG, {24'h0, ~seed[31:24]});
      cyc(3);
      `CHK(do_o, m_do)
    end
    acc(1'b1, iopim_pkg::ADDR_CFG, {16'h0, m_pat, 8'h07});
    cyc(3);
    `CHK(do_o, m_do)
    $display("test substitute done");
    acc(1'b1, iopim_pkg::ADDR_CFG, 32'h0000_a501);
    cyc(3);
    `CHK(do_o, 4'hf)
    selector_i <= 4'hf;
    cyc(7);
    `CHK(do_o, 4'h0)
    acc(1'b0, iopim_pkg::ADDR_CFG, 32'h0); `CHK(q[15:0], 16'h0000)
    selector_i <= 4'h0;
    $display("test defaults done");
    acc(1'b0, iopim_pkg::ADDR_IRQ_STAT, 32'h0);
    for (int t = 0; t < 3; t++) begin
      seed = lfsr(seed);
      acc(1'b1, iopim_pkg::ADDR_CTRL, u_scan.ctrl_word(2'(t), seed[0]));
    end
    cyc(3);
    acc(1'b0, iopim_pkg::ADDR_CONN_STAT, 32'h0); `CHK(q[4:0], 5'h08)
    `CHK(conn_up_o, 1'b0)
    `CHK(irq_o, 1'b0)
    acc(1'b1, iopim_pkg::ADDR_IRQ_MASK, 32'h8);
    cyc(2);
    `CHK(irq_o, 1'b1)
    acc(1'b0, iopim_pkg::ADDR_IRQ_STAT, 32'h0); `CHK(q[3:0], 4'h8)
    cyc(2);
    `CHK(irq_o, 1'b0)
    $display("test boot refusal done");
    acc(1'b1, iopim_pkg::ADDR_IRQ_MASK, 32'h4);
    `CHK(ring_fault_o, 1'b0)
    beacon_en <= 1'b0;
    cyc(60010);
    `CHK(ring_fault_o, 1'b1)
    `CHK(irq_o, 1'b1)
    acc(1'b0, iopim_pkg::ADDR_IRQ_STAT, 32'h0); `CHK(q[3:0], 4'h4)
    beacon_en <= 1'b1;
    cyc(1010);
    `CHK(ring_fault_o, 1'b0)
    `CHK(irq_o, 1'b0)
    $display("test ring done");
    stop_test();
  end
endmodule // testbench
